/* File: design/acw_pkg.sv */
// Package of the serial configuration word link: field positions, codes, timing.
// Assumes a 125 MHz ref_clk on both ends.
package acw_pkg;
   localparam int WORD_W = 12;
   localparam int FRAME_BITS = 16;
   localparam int LOAD_EDGES = 12;
   localparam int MUX_EDGE = 14;
   localparam int BIT_LOAD = 11;
   localparam int BIT_CHAIN = 10;
   localparam int BIT_CH_HI = 8;
   localparam int BIT_CH_LO = 6;
   localparam int BIT_PWR_HI = 5;
   localparam int BIT_PWR_LO = 4;
   localparam int BIT_ALT = 3;
   localparam int BIT_SPAN = 1;
   localparam int BIT_FMT = 0;
   localparam logic [1:0] PWR_NORMAL = 2'h3;
   localparam logic [1:0] PWR_FULL_OFF = 2'h2;
   localparam logic [1:0] PWR_AUTO_OFF = 2'h1;
   localparam logic [1:0] PWR_INVALID = 2'h0;
   localparam logic [11:0] CFG_RESET = 12'h030;
   localparam int REF_CLK_MHZ = 125;
   localparam int WAKE_NS = 1000;
   localparam int WAKE_CYC = (WAKE_NS * REF_CLK_MHZ + 999) / 1000;
   localparam int SCLK_HALF_DIV = 5;
endpackage : acw_pkg

/* File: design/acw_link_if.sv */
// Serial link between host and converter: chip select, clock, data in/out.
`timescale 1ns/1ps
interface acw_link_if;
   logic csN;
   logic sclk;
   logic dataIn;
   logic dataOut;
   modport host (output csN, output sclk, output dataIn, input dataOut);
   modport dev (input csN, input sclk, input dataIn, output dataOut);
endinterface : acw_link_if

/* File: design/acw_device.sv */
// Converter end: captures the configuration word and returns address and result.
// Assumes link pins are asynchronous to ref_clk; sclk sampled by ref_clk.
//
// Operation
// - 12-bit write-only configuration word held
// - Sample data input on sclk falling
// - New word governs next conversion only
// - Host gives sixteen clocks per frame
// - Only first twelve falling edges loaded
// - Word sent MSB first, bit 11
// - Fixed bit layout of word fields
// - Load gate bit enables word update
// - Chain and alternate bits pick sequencer
// - Channel pick latched at conversion end
// - Channel code is plain binary index
// - Channel address precedes result bits out
// - Mux switches on fourteenth falling edge
// - Power 11 keeps fully powered
// - Power 10 shuts down, holds word
// - Power 01 shuts down after conversion
// - Host waits one microsecond after wakeup; host waits it before csN falls, and only after auto shutdown
// - Host never loads power code 00
// - Span bit: 0 double, 1 single
// - Format bit: 0 twos, 1 binary
// - Sequencer off: pick selects next channel
`timescale 1ns/1ps
module acw_device
   import acw_pkg::*;
(
   input wire logic ref_clk, // System clock
   input wire logic rstn, // Synchronous reset, active low
   input wire logic clkEn, // Freezes all state while low
   acw_link_if.dev link, // Serial link
   input wire logic [11:0] sampleCode, // Raw converter result, straight binary
   output logic [2:0] muxChannel, // Channel the input mux points at
   output logic [1:0] powerMode, // Active power field
   output logic poweredDown, // Analog core shut down
   output logic spanSingle, // Input span zero to reference
   output logic codeStraight, // Straight binary coding
   output logic [1:0] seqMode, // Chain and alternate bits
   output logic altListLoad // Next frame loads channel list
);
   import acw_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers: three stages, a change counts when stages 2 and 3 agree
   logic [2:0] csSync, clkSync, dinSync;
   logic csLvl, clkLvl, dinLvl;
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         csSync <= 3'h7;
         clkSync <= 3'h7;
         dinSync <= 3'h0;
      end else if (clkEn) begin
         csSync <= {csSync[1:0], link.csN};
         clkSync <= {clkSync[1:0], link.sclk};
         dinSync <= {dinSync[1:0], link.dataIn};
      end
   end
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         csLvl <= 1'b1;
         clkLvl <= 1'b1;
         dinLvl <= 1'b0;
      end else if (clkEn) begin
         if (csSync[1] == csSync[2]) csLvl <= csSync[2];
         if (clkSync[1] == clkSync[2]) clkLvl <= clkSync[2];
         if (dinSync[1] == dinSync[2]) dinLvl <= dinSync[2];
      end
   end
   wire logic clkSeen = (clkSync[1] == clkSync[2]) ? clkSync[2] : clkLvl;
   wire logic csSeen = (csSync[1] == csSync[2]) ? csSync[2] : csLvl;
   wire logic sclkFall = clkLvl & ~clkSeen & ~csLvl;
   wire logic frameStart = csLvl & ~csSeen;
   wire logic frameEnd = ~csLvl & csSeen;

   ////////////////////////////////////////////////////////////////////////////
   // Frame counting and capture
   logic [4:0] edgeCnt;
   logic [11:0] shiftIn;
   logic [11:0] cfgWord;
   logic [15:0] shiftOut;
   logic [11:0] convResult;
   logic [2:0] convChannel;
   wire logic [11:0] capWord = {shiftIn[10:0], dinLvl};
   wire logic capDone = sclkFall && (edgeCnt == 5'(LOAD_EDGES - 1));
   wire logic takeWord = capDone && capWord[BIT_LOAD];
   // Don't-care positions forced to zero so they never steer anything
   wire logic [11:0] next_cfgWord = {capWord[11:10], 1'b0, capWord[8:3], 1'b0,
      capWord[1:0]};
   wire logic muxEdge = sclkFall && (edgeCnt == 5'(MUX_EDGE - 1));
   wire logic [11:0] signedCode = {~sampleCode[11], sampleCode[10:0]};

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         edgeCnt <= 5'h00;
         shiftIn <= 12'h000;
      end else if (clkEn) begin
         if (frameStart) edgeCnt <= 5'h00;
         else if (sclkFall && edgeCnt != 5'(FRAME_BITS)) edgeCnt <= edgeCnt + 5'h01;
         if (sclkFall && edgeCnt < 5'(LOAD_EDGES)) shiftIn <= capWord[11:0];
      end
   end

   // Word is write-only: no path returns it on the link
   always_ff @(posedge ref_clk) begin
      if (!rstn) cfgWord <= CFG_RESET;
      else if (clkEn && takeWord) cfgWord <= next_cfgWord;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Conversion: sampled at frame start with the settings in force then
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         convResult <= 12'h000;
         convChannel <= 3'h0;
         shiftOut <= 16'h0000;
         link.dataOut <= 1'b0;
      end else if (clkEn) begin
         if (frameStart) begin
            convChannel <= muxChannel;
            // Coding from the previous frame's word; span is not applied to the result
            convResult <= codeStraight ? sampleCode : signedCode;
            shiftOut <= 16'h0000;
            link.dataOut <= 1'b0;
         end else if (sclkFall) begin
            if (edgeCnt == 5'h00)
               // Two zeros, two address bits, then result
               shiftOut <= {1'b0, convChannel[1:0], convResult, 1'b0};
            else
               shiftOut <= {shiftOut[14:0], 1'b0};
            link.dataOut <= (edgeCnt == 5'h00) ? 1'b0 : shiftOut[15];
         end else if (frameEnd) link.dataOut <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Mux, power and mode outputs
   wire logic [1:0] newPower = next_cfgWord[BIT_PWR_HI:BIT_PWR_LO];
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         muxChannel <= 3'h0;
         powerMode <= PWR_NORMAL;
         poweredDown <= 1'b0;
         spanSingle <= 1'b0;
         codeStraight <= 1'b0;
         seqMode <= 2'h0;
         altListLoad <= 1'b0;
      end else if (clkEn) begin
         // Binary pick index goes straight to the mux
         if (muxEdge) muxChannel <= cfgWord[BIT_CH_HI:BIT_CH_LO];
         if (takeWord) begin
            powerMode <= newPower;
            spanSingle <= next_cfgWord[BIT_SPAN];
            codeStraight <= next_cfgWord[BIT_FMT];
            seqMode <= {next_cfgWord[BIT_CHAIN], next_cfgWord[BIT_ALT]};
            altListLoad <= ~next_cfgWord[BIT_CHAIN] & next_cfgWord[BIT_ALT];
         end else if (capDone) altListLoad <= 1'b0;
         if (takeWord && newPower == PWR_NORMAL) poweredDown <= 1'b0;
         else if (takeWord && newPower == PWR_FULL_OFF) poweredDown <= 1'b1;
         else if (frameEnd && powerMode == PWR_AUTO_OFF) poweredDown <= 1'b1;
         else if (frameStart && powerMode == PWR_AUTO_OFF) poweredDown <= 1'b0;
      end
   end
endmodule : acw_device

/* File: design/acw_host.sv */
// Host end: sends one 16-clock frame per request and returns the read word.
// Assumes the device end of acw_link_if; drives sclk by division of ref_clk.
`timescale 1ns/1ps
module acw_host
   import acw_pkg::*;
(
   input wire logic ref_clk, // System clock
   input wire logic rstn, // Synchronous reset, active low
   input wire logic clkEn, // Freezes all state while low
   acw_link_if.host link, // Serial link
   input wire logic [2:0] addr, // 0 word to send, 1 start, 2 status, 3 last read
   input wire logic [15:0] wdata, // Write data
   input wire logic wr, // Write strobe
   input wire logic rd, // Read strobe
   output logic [15:0] rdata // Read data, cycle after rd
);
   import acw_pkg::*;

   typedef enum logic [3:0] {
      ACWH_IDLE = 4'h1, ACWH_WAKE = 4'h2, ACWH_HIGH = 4'h4, ACWH_LOW = 4'h8
   } acwh_state_t;

   acwh_state_t state;
   logic [11:0] txWord;
   logic [15:0] txShift, rxShift, rxWord;
   logic [4:0] bitCnt;
   logic [7:0] divCnt;
   logic [7:0] wakeCnt;
   logic [2:0] dinSync;
   logic dinLvl;
   logic autoOff;
   wire logic divDone = (divCnt == 8'(SCLK_HALF_DIV - 1));
   // Divider restarts when the frame opens, so the first half period is full length
   wire logic divHold = (state == ACWH_IDLE) || (state == ACWH_WAKE) || divDone;
   wire logic startReq = wr && addr == 3'h1 && state == ACWH_IDLE;
   // Power code 00 is never sent: it is replaced by normal operation
   wire logic [11:0] safeWord = (wdata[BIT_PWR_HI:BIT_PWR_LO] == PWR_INVALID) ?
      (wdata[11:0] | 12'h030) : wdata[11:0];
   wire logic [15:0] status = {15'h0000, state != ACWH_IDLE};
   wire logic [15:0] next_rdata = (addr == 3'h0) ? {4'h0, txWord} :
      (addr == 3'h2) ? status : (addr == 3'h3) ? rxWord : 16'h0000;

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         dinSync <= 3'h0;
         dinLvl <= 1'b0;
      end else if (clkEn) begin
         dinSync <= {dinSync[1:0], link.dataOut};
         if (dinSync[1] == dinSync[2]) dinLvl <= dinSync[2];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) rdata <= 16'h0000;
      else if (clkEn && rd) rdata <= next_rdata;
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         txWord <= CFG_RESET;
         autoOff <= 1'b0;
      end else if (clkEn && wr && addr == 3'h0) txWord <= safeWord;
      else if (clkEn && startReq && txWord[BIT_LOAD])
         autoOff <= txWord[BIT_PWR_HI:BIT_PWR_LO] == PWR_AUTO_OFF;
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         state <= ACWH_IDLE;
         link.csN <= 1'b1;
         link.sclk <= 1'b1;
         link.dataIn <= 1'b0;
         txShift <= 16'h0000;
         rxShift <= 16'h0000;
         rxWord <= 16'h0000;
         bitCnt <= 5'h00;
         divCnt <= 8'h00;
         wakeCnt <= 8'h00;
      end else if (clkEn) begin
         divCnt <= divHold ? 8'h00 : divCnt + 8'h01;
         unique case (state)
            ACWH_IDLE: if (startReq) begin
               // Auto shutdown: wait out the wake-up time first
               state <= autoOff ? ACWH_WAKE : ACWH_HIGH;
               wakeCnt <= 8'h00;
               link.csN <= autoOff;
               // First bit stands a whole half period before the first fall
               link.dataIn <= txWord[11];
               txShift <= {txWord[10:0], 5'h00};
               bitCnt <= 5'h00;
            end
            ACWH_WAKE: begin
               wakeCnt <= wakeCnt + 8'h01;
               if (wakeCnt == 8'(WAKE_CYC - 1)) begin
                  state <= ACWH_HIGH;
                  link.csN <= 1'b0;
               end
            end
            ACWH_HIGH: if (divDone) begin
               // Both synchronisers delay the returned bit: take it a full period late
               if (bitCnt != 5'h00) rxShift <= {rxShift[14:0], dinLvl};
               if (bitCnt == 5'(FRAME_BITS)) begin
                  state <= ACWH_IDLE;
                  link.csN <= 1'b1;
                  link.dataIn <= 1'b0;
                  rxWord <= {rxShift[14:0], dinLvl};
               end else begin
                  link.sclk <= 1'b0;
                  state <= ACWH_LOW;
               end
            end
            ACWH_LOW: if (divDone) begin
               link.sclk <= 1'b1;
               // Data moves on the rise so it is settled at the device's fall
               link.dataIn <= txShift[15];
               txShift <= {txShift[14:0], 1'b0};
               bitCnt <= bitCnt + 5'h01;
               state <= ACWH_HIGH;
            end
         endcase
      end
   end
endmodule : acw_host

/* File: test/acw_link_asserts.sv */
// Concurrent checks on the serial link between host and device ends.
// Assumes all link pins are sampled by ref_clk; instantiated beside the interface.
`timescale 1ns/1ps
module acw_link_asserts (
   input wire logic ref_clk, // System clock
   input wire logic rstn, // Sync reset, active low
   input wire logic csN, // Frame select
   input wire logic sclk, // Link clock
   input wire logic dataIn, // Host to device
   input wire logic dataOut // Device to host
);
   logic sclkQ;
   logic csNQ;
   logic [4:0] falls;
   logic [11:0] shiftIn;
   logic [2:0] expCh;
   wire fallSeen = sclkQ & ~sclk;
   wire frameEnd = csN & ~csNQ;
   ////////////////////////////////////////////////////////////////
   // Count falls in frame; rebuild the word to predict the address
   always_ff @(posedge ref_clk) begin
      sclkQ <= sclk;
      csNQ <= csN;
      falls <= (!rstn || csN) ? 5'h00 : falls + {4'h0, fallSeen};
   end
   always_ff @(posedge ref_clk) begin
      if (fallSeen && !csN && falls < 5'h0C) begin
         shiftIn <= {shiftIn[10:0], dataIn};
      end
   end
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         expCh <= 3'h0;
      end else if (frameEnd && shiftIn[11]) begin
         expCh <= shiftIn[8:6];
      end
   end
   ////////////////////////////////////////////////////////////////
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   chk_sclk_idle_high: assert property (csN |-> sclk)
      else $error("link clock low outside frame");
   chk_sclk_low_half: assert property ($fell(sclk) |-> (!sclk)[*5] ##1 sclk)
      else $error("link clock low phase wrong");
   chk_sclk_high_half: assert property
      ($rose(sclk) && !csN |-> sclk[*5] ##1 (!sclk || csN))
      else $error("link clock high phase wrong");
   chk_frame_sixteen: assert property ($rose(csN) |-> falls == 5'h10)
      else $error("frame without sixteen clocks");
   chk_cs_lead: assert property ($fell(csN) |-> sclk ##[1:8] $fell(sclk))
      else $error("first clock fall late");
   chk_data_at_rise: assert property
      (!csN && !$fell(csN) && $changed(dataIn) |-> $rose(sclk))
      else $error("data in moved off clock rise");
   chk_lead_zero: assert property ($rose(sclk) && !csN && falls <= 5'h02 |-> !dataOut)
      else $error("leading bit not zero");
   chk_addr_high: assert property ($rose(sclk) && falls == 5'h03 |-> dataOut == expCh[1])
      else $error("address high bit wrong");
   chk_addr_low: assert property ($rose(sclk) && falls == 5'h04 |-> dataOut == expCh[0])
      else $error("address low bit wrong");
   cover property ($rose(csN));
   cover property ($rose(sclk) && falls == 5'h03 && dataOut);
   cover property (frameEnd && shiftIn[11]);
endmodule : acw_link_asserts

/* File: test/tb_adc_serial_control_word.sv */
// Testbench: host and device ends joined by the link, driven via host registers.
// Assumes 125 MHz ref_clk and the register map of the host end.
`timescale 1ns/1ps
`define CHK(a, b) begin nCompared++; if ((a) !== (b)) begin miscompares++; \
   $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module tb_adc_serial_control_word;
   import acw_pkg::*;
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   logic [2:0] addr = 3'h0;
   logic [15:0] wdata = 16'h0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [15:0] rdata, rx;
   logic [11:0] sampleCode = 12'h000;
   logic [2:0] muxChannel;
   logic [1:0] powerMode, seqMode;
   logic poweredDown, spanSingle, codeStraight, altListLoad;
   logic [11:0] pw [6] = '{12'h820, 12'h7FF, 12'h830, 12'h810, 12'h830, 12'h800};
   logic [1:0] pmExp [6] = '{2'h2, 2'h2, 2'h3, 2'h1, 2'h3, 2'h3};
   logic [5:0] pdExp = 6'h0B;
   int miscompares = 0;
   int nCompared = 0;
   int lat;
   acw_link_if link ();
   acw_host u_acw_host (.ref_clk(ref_clk), .rstn(rstn), .clkEn(1'b1), .link(link),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
   acw_device u_acw_device (.ref_clk(ref_clk), .rstn(rstn), .clkEn(1'b1), .link(link),
      .sampleCode(sampleCode), .muxChannel(muxChannel), .powerMode(powerMode),
      .poweredDown(poweredDown), .spanSingle(spanSingle), .codeStraight(codeStraight),
      .seqMode(seqMode), .altListLoad(altListLoad));
   acw_link_asserts u_acw_link_asserts (.ref_clk(ref_clk), .rstn(rstn), .csN(link.csN),
      .sclk(link.sclk), .dataIn(link.dataIn), .dataOut(link.dataOut));
   always #4 ref_clk = ~ref_clk;
   ////////////////////////////////////////////////////////////////
   function automatic logic [11:0] coded(input logic [11:0] c, input logic s);
      return s ? c : {~c[11], c[10:0]};
   endfunction : coded
   task automatic summarize();
      $display("Compared %0d, mismatches %0d", nCompared, miscompares);
      if (miscompares == 0 && nCompared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : summarize
   task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge ref_clk);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [2:0] a);
      @(posedge ref_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge ref_clk);
      rd <= 1'b0;
      #1 rx = rdata;
   endtask : rd_reg
   // One full frame; leaves the received word in rx
   task automatic frame(input logic [11:0] w, input logic [11:0] c);
      int n;
      wr_reg(3'h0, {4'h0, w});
      sampleCode <= c;
      wr_reg(3'h1, 16'h0001);
      for (lat = 0; link.csN !== 1'b0 && lat < 400; lat++) @(posedge ref_clk) #1;
      rx = 16'h0001;
      for (n = 0; rx[0] !== 1'b0 && n < 300; n++) rd_reg(3'h2);
      if (n == 300 || lat == 400) begin
         miscompares++;
         summarize();
      end
      rd_reg(3'h3);
      // Device sees the frame end only after its pin synchronisers
      repeat (4) @(posedge ref_clk);
      #1;
   endtask : frame
   ////////////////////////////////////////////////////////////////
   task automatic t_channels();
      logic [11:0] w, c, prev;
      prev = CFG_RESET;
      for (int k = 0; k < 9; k++) begin
         w = {3'h5, k[2:0], 2'h3, 2'h1, k[1:0]};
         c = 12'h5A3 ^ {3{k[3:0]}};
         frame(w, c);
         `CHK(muxChannel, k[2:0])
         `CHK(rx, {2'h0, prev[7:6], coded(c, prev[0])})
         `CHK(spanSingle, w[1])
         `CHK(codeStraight, w[0])
         `CHK(seqMode, 2'h0)
         prev = w;
      end
   endtask : t_channels
   task automatic t_gate();
      frame(12'h7FE, 12'h800);
      `CHK({muxChannel, seqMode, spanSingle}, 6'h00)
   endtask : t_gate
   task automatic t_power();
      for (int i = 0; i < 6; i++) begin
         frame(pw[i], 12'h123);
         `CHK(powerMode, pmExp[i])
         `CHK(poweredDown, pdExp[i])
         if (i == 4) `CHK(lat >= WAKE_CYC, 1'b1)
      end
      rd_reg(3'h0);
      `CHK(rx, 16'h0830)
   endtask : t_power
   task automatic t_seq();
      frame(12'hC30, 12'h321);
      `CHK(seqMode, 2'h2)
      frame(12'h838, 12'h321);
      `CHK({seqMode, altListLoad}, 3'h3)
      frame(12'h030, 12'h321);
      `CHK(altListLoad, 1'b0)
      frame(12'h830, 12'h321);
      rd_reg(3'h5);
      `CHK(rx, 16'h0000)
   endtask : t_seq
   initial begin
      repeat (8) @(posedge ref_clk);
      rstn <= 1'b1;
      `CHK({muxChannel, powerMode, poweredDown, spanSingle, codeStraight, seqMode}, 10'h060)
      t_channels();
      t_gate();
      t_power();
      t_seq();
      summarize();
   end
endmodule : tb_adc_serial_control_word
